// file: dmsi_pkg.sv
// Constants shared by the four-channel serial block.
// Assumes a 20 MHz peripheral clock and the plain register port.
`default_nettype none

package dmsi_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int NCH = 4;
  localparam int NDUAL = 2;
  localparam int AW = 8;
  localparam int DW = 16;
  localparam int FRW = 13;
  localparam int CLK_HZ = 20000000;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] CS_LAST = 4'h7;

  // ****************************************
  // Register offsets within a channel
  // ****************************************
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_BAUD = 4'h4;
  localparam logic [3:0] R_DATA = 4'h8;
  localparam logic [3:0] R_STAT = 4'hc;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int C_TXEN = 0;
  localparam int C_RXEN = 1;
  localparam int C_CLOCK_SYNCHRONOUS_MODE = 2;
  localparam int C_EXT = 3;
  localparam int C_POL = 4;
  localparam int C_LEN = 5;
  localparam int C_PEN = 7;
  localparam int C_ODD = 8;
  localparam int C_STP2 = 9;
  localparam int C_SRC = 10;
  localparam int C_CKO = 12;
  localparam int CW = 13;
  localparam logic [CW-1:0] CTRL_RST = 13'h0020;
  localparam logic [7:0] BAUD_RST = 8'hff;

  // ****************************************
  // Status fields
  // ****************************************
  localparam int S_TXE = 0;
  localparam int S_TBSY = 1;
  localparam int S_TFIN = 2;
  localparam int S_RXF = 3;
  localparam int S_OVR = 4;
  localparam int S_PAR = 5;
  localparam int S_FRM = 6;
  localparam int S_ERR = 7;
endpackage

`default_nettype wire

// file: dmsi_top.sv
// Four-channel serial block: two dual-mode channels, two UART-only.
// Assumes registers driven by a same-clock master; pins are asynchronous.
//
// Function
// - four channels, zero and one dual-mode
// - synchronous mode moves eight bits per transfer
// - always least significant bit first
// - character length seven, eight or nine
// - parity odd, even or none
// - one or two stop bits
// - synchronous clock internal or external, polarity
// - UART timing only from baud divider
// - count source undivided, /8, /32, /256
// - transmit, receive, or both at once
// - synchronous mode flags only overrun
// - UART flags overrun, parity, framing, sum
// - channels zero and one in UART mode drive divider clock halved
// - separate transmit and receive DMA requests
// - synchronous rates 152 b/s to 10 Mb/s
// - UART rates 19 b/s to 1.25 Mb/s
// - transmit-finished only with internal clock
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module dmsi_top
  #(parameter int NCH = dmsi_pkg::NCH)
  (
  // Clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   reset_i,
  // Register port
  input  wire logic [dmsi_pkg::AW-1:0] addr_i,
  input  wire logic [dmsi_pkg::DW-1:0] wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [dmsi_pkg::DW-1:0] rdata_o,
  // Serial pins
  input  wire logic [NCH-1:0]         rxd_i,
  input  wire logic [NCH-1:0]         sclk_i,
  output logic      [NCH-1:0]         txd_o,
  output logic      [NCH-1:0]         sclk_o,
  output logic      [NCH-1:0]         sclk_oe_o,
  // DMA requests
  output logic      [NCH-1:0]         tx_dreq_o,
  output logic      [NCH-1:0]         rx_dreq_o
  );

  // ****************************************
  // Shared prescaler
  // ****************************************
  logic [7:0]                pre_ff;
  logic [3:0]                src_tap;
  logic [dmsi_pkg::DW-1:0]   rv [NCH];
  logic [dmsi_pkg::DW-1:0]   rdata_ff;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      pre_ff <= 8'h00;
    else
      pre_ff <= pre_ff + 8'h01;
  end

  // Taps for the four count sources
  assign src_tap = {&pre_ff, &pre_ff[4:0], &pre_ff[2:0], 1'b1};

  // ****************************************
  // Channels
  // ****************************************
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    // Only the first two channels own the synchronous mode
    localparam bit DUAL = (c < dmsi_pkg::NDUAL);

    logic [dmsi_pkg::CW-1:0] ctrl_ff;
    logic [7:0]  baud_ff, brg_ff;
    logic [8:0]  tbuf_ff, rbuf_ff, rsh_ff;
    logic [dmsi_pkg::FRW-1:0] tsh_ff;
    logic [3:0]  tcnt_ff, tos_ff, ros_ff, ridx_ff;
    logic [2:0]  rs_ff, cs_ff;
    logic        rlvl_ff, clvl_ff, pbit_ff;
    logic        tfull_ff, tbusy_ff, txd_ff, sclk_ff, oe_ff;
    logic        rbusy_ff, rfull_ff, ovr_ff, perr_ff, ferr_ff, tfin_ff;
    logic        txr_ff, rxr_ff;
    logic        hit, wr_ctl, wr_bd, wr_dat, wr_st, rd_dat;
    logic        clock_synchronous_mode, ext, idle, tick, tx_en, rx_en, pen, odd;
    logic        redge, fall, cedge, lead_x, lead, trail;
    logic        tx_go, tx_end, mid, u_stop, cs_done, rx_done;
    logic        ferr_ev, perr_ev;
    logic [3:0]  ndat, ulast, par_idx, stp_idx;
    logic [8:0]  dmask, rnew;
    logic [dmsi_pkg::FRW-1:0] uframe;

    assign hit    = (addr_i[7:6] == 2'h0) && (addr_i[5:4] == 2'(c));
    assign wr_ctl = wr_i && hit && (addr_i[3:0] == dmsi_pkg::R_CTRL);
    assign wr_bd  = wr_i && hit && (addr_i[3:0] == dmsi_pkg::R_BAUD);
    assign wr_dat = wr_i && hit && (addr_i[3:0] == dmsi_pkg::R_DATA);
    assign wr_st  = wr_i && hit && (addr_i[3:0] == dmsi_pkg::R_STAT);
    assign rd_dat = rd_i && hit && (addr_i[3:0] == dmsi_pkg::R_DATA);

    // Full-duplex, or either half alone
    assign tx_en = ctrl_ff[dmsi_pkg::C_TXEN];
    assign rx_en = ctrl_ff[dmsi_pkg::C_RXEN];
    assign clock_synchronous_mode  = DUAL && ctrl_ff[dmsi_pkg::C_CLOCK_SYNCHRONOUS_MODE];
    // UART ignores the external clock select
    assign ext   = clock_synchronous_mode && ctrl_ff[dmsi_pkg::C_EXT];
    assign idle  = ~ctrl_ff[dmsi_pkg::C_POL];
    assign pen   = ctrl_ff[dmsi_pkg::C_PEN];
    assign odd   = ctrl_ff[dmsi_pkg::C_ODD];
    assign ndat  = 4'h7 + {2'h0, ctrl_ff[dmsi_pkg::C_LEN +: 2]};
    assign dmask = 9'h1ff >> (4'h9 - ndat);
    assign par_idx = ndat + 4'h1;
    assign stp_idx = par_idx + {3'h0, pen};
    assign ulast = stp_idx + {3'h0, ctrl_ff[dmsi_pkg::C_STP2]};

    always_ff @(posedge mclk_i)
    begin
      if (reset_i)
      begin
        ctrl_ff <= dmsi_pkg::CTRL_RST;
        baud_ff <= dmsi_pkg::BAUD_RST;
      end
      else
      begin
        if (wr_ctl)
          ctrl_ff <= wdata_i[dmsi_pkg::CW-1:0];
        if (wr_bd)
          baud_ff <= wdata_i[7:0];
      end
    end

    // Reload divider: rate = source/(baud+1); 16x for UART, 2x synchronous
    assign tick = src_tap[ctrl_ff[dmsi_pkg::C_SRC +: 2]] && (brg_ff == 8'h00);

    always_ff @(posedge mclk_i)
    begin
      if (reset_i)
        brg_ff <= dmsi_pkg::BAUD_RST;
      else if (wr_bd)
        brg_ff <= wdata_i[7:0];
      else if (src_tap[ctrl_ff[dmsi_pkg::C_SRC +: 2]])
        brg_ff <= (brg_ff == 8'h00) ? baud_ff : brg_ff - 8'h01;
    end

    // Pin synchronisers; a change counts when stages two and three agree
    always_ff @(posedge mclk_i)
    begin
      if (reset_i)
      begin
        rs_ff   <= 3'h7;
        cs_ff   <= 3'h7;
        rlvl_ff <= 1'b1;
        clvl_ff <= 1'b1;
      end
      else
      begin
        rs_ff <= {rs_ff[1:0], rxd_i[c]};
        cs_ff <= {cs_ff[1:0], sclk_i[c]};
        if (rs_ff[1] == rs_ff[2])
          rlvl_ff <= rs_ff[2];
        if (cs_ff[1] == cs_ff[2])
          clvl_ff <= cs_ff[2];
      end
    end

    assign redge  = (rs_ff[1] == rs_ff[2]) && (rs_ff[2] != rlvl_ff);
    assign fall   = redge && !rs_ff[2];
    // External clock edges; peer keeps it at or below clock/16
    assign cedge  = (cs_ff[1] == cs_ff[2]) && (cs_ff[2] != clvl_ff);
    assign lead_x = ext && cedge && (cs_ff[2] != idle);
    assign lead   = ext ? lead_x : (tick && tbusy_ff && sclk_ff == idle);
    assign trail  = ext ? (cedge && cs_ff[2] == idle) : (tick && tbusy_ff && sclk_ff != idle);

    // ****************************************
    // Transmitter
    // ****************************************
    always_comb
    begin
      uframe = '1;
      uframe[0] = 1'b0;
      for (int i = 0; i < 9; i++)
        if (4'(i) < ndat)
          uframe[i+1] = tbuf_ff[i];
      if (pen)
        uframe[par_idx] = ^(tbuf_ff & dmask) ^ odd;
    end

    // Internal synchronous receive-only keeps clocking until a read is owed
    assign tx_go = !tbusy_ff && (clock_synchronous_mode ?
                   (ext ? lead_x && (tx_en || rx_en)
                        : (tx_en && tfull_ff) || (rx_en && !tx_en && !rfull_ff))
                   : tx_en && tfull_ff);
    assign tx_end = tbusy_ff && (clock_synchronous_mode ? trail && tcnt_ff == dmsi_pkg::CS_LAST
                    : tick && tos_ff == dmsi_pkg::OVS_LAST && tcnt_ff == ulast);

    always_ff @(posedge mclk_i)
    begin
      if (reset_i)
      begin
        tbusy_ff <= 1'b0;
        tsh_ff   <= '1;
        tcnt_ff  <= 4'h0;
        tos_ff   <= 4'h0;
        txd_ff   <= 1'b1;
      end
      else if (tx_go)
      begin
        tbusy_ff <= 1'b1;
        tcnt_ff  <= 4'h0;
        tos_ff   <= 4'h0;
        if (clock_synchronous_mode)
        begin
          tsh_ff <= {5'h1f, (tx_en && tfull_ff) ? tbuf_ff[7:0] : 8'hff};
          txd_ff <= (tx_en && tfull_ff) ? tbuf_ff[0] : 1'b1;
        end
        else
        begin
          tsh_ff <= uframe;
          txd_ff <= 1'b0;
        end
      end
      else if (tbusy_ff && clock_synchronous_mode)
      begin
        // Data changes on the leading edge, peer samples on the trailing
        if (lead)
          txd_ff <= tsh_ff[0];
        if (trail)
        begin
          tsh_ff  <= {1'b1, tsh_ff[dmsi_pkg::FRW-1:1]};
          tcnt_ff <= tcnt_ff + 4'h1;
          if (tcnt_ff == dmsi_pkg::CS_LAST)
            tbusy_ff <= 1'b0;
        end
      end
      else if (tbusy_ff && tick)
      begin
        tos_ff <= tos_ff + 4'h1;
        if (tos_ff == dmsi_pkg::OVS_LAST)
        begin
          tsh_ff  <= {1'b1, tsh_ff[dmsi_pkg::FRW-1:1]};
          txd_ff  <= tsh_ff[1];
          tcnt_ff <= tcnt_ff + 4'h1;
          if (tcnt_ff == ulast)
            tbusy_ff <= 1'b0;
        end
      end
      else if (!tbusy_ff && !clock_synchronous_mode)
        txd_ff <= 1'b1;
    end

    // ****************************************
    // Receiver
    // ****************************************
    assign mid     = !clock_synchronous_mode && rbusy_ff && tick && ros_ff == dmsi_pkg::OVS_MID;
    assign u_stop  = mid && ridx_ff == stp_idx;
    assign cs_done = clock_synchronous_mode && tbusy_ff && trail && tcnt_ff == dmsi_pkg::CS_LAST && rx_en;
    assign rx_done = u_stop || cs_done;
    assign rnew    = clock_synchronous_mode ? {1'b0, rlvl_ff, rsh_ff[6:0]} : (rsh_ff & dmask);
    // Parity and framing only exist in UART mode
    assign ferr_ev = u_stop && !rlvl_ff;
    assign perr_ev = u_stop && pen && (^rnew ^ pbit_ff ^ odd);

    always_ff @(posedge mclk_i)
    begin
      if (reset_i)
      begin
        rbusy_ff <= 1'b0;
        ros_ff   <= 4'h0;
        ridx_ff  <= 4'h0;
        rsh_ff   <= 9'h000;
        pbit_ff  <= 1'b0;
      end
      else if (clock_synchronous_mode)
      begin
        rbusy_ff <= 1'b0;
        if (tbusy_ff && trail)
          rsh_ff[tcnt_ff[2:0]] <= rlvl_ff;
      end
      else if (!rbusy_ff)
      begin
        if (rx_en && fall)
        begin
          rbusy_ff <= 1'b1;
          ros_ff   <= 4'h0;
          ridx_ff  <= 4'h0;
        end
      end
      else if (tick)
      begin
        ros_ff <= ros_ff + 4'h1;
        if (ros_ff == dmsi_pkg::OVS_MID)
        begin
          ridx_ff <= ridx_ff + 4'h1;
          // A start bit gone high by mid-bit was a glitch
          if ((ridx_ff == 4'h0 && rlvl_ff) || ridx_ff == stp_idx)
            rbusy_ff <= 1'b0;
          else if (pen && ridx_ff == par_idx)
            pbit_ff <= rlvl_ff;
          else if (ridx_ff != 4'h0)
            rsh_ff[ridx_ff - 4'h1] <= rlvl_ff;
        end
      end
    end

    // ****************************************
    // Buffers and sticky flags; a set beats a clear
    // ****************************************
    always_ff @(posedge mclk_i)
    begin
      if (reset_i)
      begin
        tbuf_ff  <= 9'h000;
        tfull_ff <= 1'b0;
        rbuf_ff  <= 9'h000;
        rfull_ff <= 1'b0;
        ovr_ff   <= 1'b0;
        perr_ff  <= 1'b0;
        ferr_ff  <= 1'b0;
        tfin_ff  <= 1'b0;
      end
      else
      begin
        if (wr_dat)
          tbuf_ff <= wdata_i[8:0];
        tfull_ff <= wr_dat || (tfull_ff && !(tx_go && tx_en));
        if (rx_done)
          rbuf_ff <= rnew;
        rfull_ff <= rx_done || (rfull_ff && !rd_dat);
        ovr_ff  <= (rx_done && rfull_ff && !rd_dat)
                   || (ovr_ff && !(wr_st && wdata_i[dmsi_pkg::S_OVR]));
        perr_ff <= perr_ev || (perr_ff && !(wr_st && wdata_i[dmsi_pkg::S_PAR]));
        ferr_ff <= ferr_ev || (ferr_ff && !(wr_st && wdata_i[dmsi_pkg::S_FRM]));
        tfin_ff <= (tx_end && !ext)
                   || (tfin_ff && !(wr_st && wdata_i[dmsi_pkg::S_TFIN]));
      end
    end

    // ****************************************
    // Clock pin and DMA requests
    // ****************************************
    always_ff @(posedge mclk_i)
    begin
      if (reset_i)
      begin
        sclk_ff <= 1'b1;
        oe_ff   <= 1'b0;
        txr_ff  <= 1'b0;
        rxr_ff  <= 1'b0;
      end
      else
      begin
        txr_ff <= tx_en && !tfull_ff;
        rxr_ff <= rfull_ff;
        if (!DUAL)
        begin
          sclk_ff <= 1'b1;
          oe_ff   <= 1'b0;
        end
        else if (!clock_synchronous_mode)
        begin
          // Fixed-period output toggles per divider tick
          oe_ff <= ctrl_ff[dmsi_pkg::C_CKO];
          if (tick)
            sclk_ff <= !sclk_ff;
        end
        else
        begin
          oe_ff <= !ext;
          if (tx_go || !tbusy_ff || ext)
            sclk_ff <= idle;
          else if (tick)
            sclk_ff <= !sclk_ff;
        end
      end
    end

    assign txd_o[c]     = txd_ff;
    assign sclk_o[c]    = sclk_ff;
    assign sclk_oe_o[c] = oe_ff;
    assign tx_dreq_o[c] = txr_ff;
    assign rx_dreq_o[c] = rxr_ff;

    always_comb
    begin
      rv[c] = '0;
      unique case (addr_i[3:0])
        dmsi_pkg::R_CTRL: rv[c][dmsi_pkg::CW-1:0] = ctrl_ff;
        dmsi_pkg::R_BAUD: rv[c][7:0] = baud_ff;
        dmsi_pkg::R_DATA: rv[c][8:0] = rbuf_ff;
        dmsi_pkg::R_STAT: rv[c][7:0] = {ovr_ff || perr_ff || ferr_ff, ferr_ff,
                                        perr_ff, ovr_ff, rfull_ff, tfin_ff, tbusy_ff, !tfull_ff};
        default:          rv[c] = '0;
      endcase
    end
  end

  // ****************************************
  // Read data, one cycle after the strobe
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      rdata_ff <= '0;
    else if (rd_i && addr_i[7:6] == 2'h0)
      rdata_ff <= rv[addr_i[5:4]];
    else
      rdata_ff <= '0;
  end

  assign rdata_o = rdata_ff;

endmodule

`default_nettype wire

// file: dmsi_top_chk.sv
// Checker for the serial block: port timing relations.
// Assumes one clock and a synchronous reset; bound onto dmsi_top.
`timescale 1ns/1ns
`default_nettype none
module dmsi_top_chk
  #(parameter int NCH = 4)
  (
  // Clock and reset
  input wire logic                    mclk_i,
  input wire logic                    reset_i,
  // Register port
  input wire logic [dmsi_pkg::AW-1:0] addr_i,
  input wire logic                    rd_i,
  input wire logic [dmsi_pkg::DW-1:0] rdata_o,
  // Pins and requests
  input wire logic [NCH-1:0]          txd_o,
  input wire logic [NCH-1:0]          sclk_oe_o,
  input wire logic [NCH-1:0]          tx_dreq_o,
  input wire logic [NCH-1:0]          rx_dreq_o
  );
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  // ****************************************
  // Properties
  // ****************************************
  a_reset_idle: assert property (disable iff (1'b0) $past(reset_i) |->
    txd_o == '1 && sclk_oe_o == '0 && tx_dreq_o == '0 && rx_dreq_o == '0 && rdata_o == '0)
    else $error("outputs not idle after reset");
  a_read_gap: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside its slot");
  a_read_unmapped: assert property ($past(rd_i) && $past(addr_i[7:6]) != 2'h0 |-> rdata_o == '0)
    else $error("unmapped read not zero");
  a_read_hole: assert property ($past(rd_i) && $past(addr_i[1:0]) != 2'h0 |-> rdata_o == '0)
    else $error("hole read not zero");
  a_uart_no_clk: assert property (sclk_oe_o[NCH-1:2] == '0)
    else $error("clock pin driven on UART-only channel");
  // Sixteen clocks per bit is the fastest UART rate
  a_bit_len_two: assert property ($changed(txd_o[2]) |=> $stable(txd_o[2]) [*8])
    else $error("channel two bit too short");
  a_bit_len_three: assert property ($changed(txd_o[3]) |=> $stable(txd_o[3]) [*8])
    else $error("channel three bit too short");
  a_rx_dreq_clr: assert property (rd_i && addr_i == 8'h28 && rx_dreq_o[2] |-> ##[1:3] !rx_dreq_o[2])
    else $error("receive request kept after read");
endmodule

bind dmsi_top dmsi_top_chk #(.NCH(NCH)) u_dmsi_top_chk (
  .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .txd_o(txd_o), .sclk_oe_o(sclk_oe_o), .tx_dreq_o(tx_dreq_o), .rx_dreq_o(rx_dreq_o));
`default_nettype wire

// file: dmsi_peer.sv
// Remote asynchronous peer: sends and samples whole frames.
// Assumes the caller builds frames start bit first and calls after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module dmsi_peer
  (
  // Clock
  input  wire logic mclk_i,
  // Serial lines
  input  wire logic line_i,
  output logic      line_o
  );
  // ****************************************
  // Frame send and capture
  // ****************************************
  initial line_o = 1'b1;
  // One start bit, then bits in order, each bitc clocks
  task automatic send(input logic [12:0] f, input int n, input int bitc);
    for (int i = 0; i < n; i++)
    begin
      line_o <= f[i];
      repeat (bitc) @(posedge mclk_i);
    end
    line_o <= 1'b1;
  endtask
  // Samples each bit at its middle after the start edge
  task automatic recv(output logic [12:0] f, input int n, input int bitc);
    int w;
    f = '0;
    w = 0;
    while (line_i && w < 4000)
    begin
      @(posedge mclk_i);
      w++;
    end
    repeat (bitc / 2) @(posedge mclk_i);
    for (int i = 0; i < n; i++)
    begin
      f[i] = line_i;
      if (i < n - 1)
        repeat (bitc) @(posedge mclk_i);
    end
  endtask
endmodule
`default_nettype wire

// file: dmsi_top_tb.sv
// Testbench for the serial block: register tasks, peer traffic, loopback.
// Assumes the peer model and the bound checker are compiled beside it.
`timescale 1ns/1ns
`default_nettype none
module dmsi_top_tb;
  logic        mclk_i;
  logic        reset_i;
  logic [7:0]  addr_i;
  logic [15:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [15:0] rdata_o;
  logic [3:0]  rxd_w;
  logic [3:0]  sclk_w;
  logic [3:0]  txd_o;
  logic [3:0]  sclk_o;
  logic [3:0]  sclk_oe_o;
  logic [3:0]  tx_dreq_o;
  logic [3:0]  rx_dreq_o;
  logic        peer_line;
  int          bad_count = 0;
  int          checks = 0;
  int          seed = 61;
  int          cyc = 0;
  // Channels zero and one loop back on themselves
  assign rxd_w = {1'b1, peer_line, txd_o[1], txd_o[0]};
  dmsi_top u_dmsi_top (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_w), .sclk_i(sclk_w), .txd_o(txd_o),
    .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .tx_dreq_o(tx_dreq_o), .rx_dreq_o(rx_dreq_o));
  dmsi_peer u_dmsi_peer (.mclk_i(mclk_i), .line_i(txd_o[2]), .line_o(peer_line));
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // ****************************************
  // Tasks and functions
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    v = rdata_o;
    @(posedge mclk_i);
  endtask
  function automatic logic [7:0] ra(input int ch, input logic [3:0] off);
    return {2'h0, 2'(ch), off};
  endfunction
  function automatic logic [12:0] frame(input logic [8:0] d, input logic [15:0] c, input logic bp,
                                        input logic bs, output int n);
    int          nd;
    logic [12:0] f;
    nd = 7 + int'(c[6:5]);
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nd; i++)
      f[1 + i] = d[i];
    if (c[7])
      f[1 + nd] = (^(d & 9'((1 << nd) - 1))) ^ c[8] ^ bp;
    n = 2 + nd + c[7] + c[9];
    if (bs)
      f[1 + nd + c[7]] = 1'b0;
    return f & 13'((1 << n) - 1);
  endfunction
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [15:0] v;
    logic [15:0] ct;
    logic [12:0] f;
    logic [12:0] g;
    logic [8:0]  d;
    logic [7:0]  sh;
    logic        bp;
    logic        bs;
    logic        s;
    int          n;
    int          k;
    int          dv [4] = '{1, 8, 32, 256};
    reset_i = 1'b1;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    sclk_w = 4'he;
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    for (int c = 0; c < 4; c++)
    begin
      rd(ra(c, dmsi_pkg::R_CTRL), v);
      chk(v, 16'(dmsi_pkg::CTRL_RST));
      rd(ra(c, dmsi_pkg::R_BAUD), v);
      chk(v, 16'(dmsi_pkg::BAUD_RST));
    end
    rd(8'h48, v);
    chk(v, 16'h0000);
    rd(8'h26, v);
    chk(v, 16'h0000);
    // Clock out on a UART channel, divider ticking every clock
    wr(ra(0, dmsi_pkg::R_BAUD), 16'h0000);
    wr(ra(0, dmsi_pkg::R_CTRL), 16'h1020);
    @(negedge mclk_i);
    s = sclk_o[0];
    chk({15'h0, sclk_oe_o[0]}, 16'h0001);
    @(negedge mclk_i);
    chk({15'h0, sclk_o[0]}, {15'h0, ~s});
    @(posedge mclk_i);
    // Every UART format, full duplex, with injected errors
    wr(ra(2, dmsi_pkg::R_BAUD), 16'h0000);
    for (int m = 0; m < 18; m++)
    begin
      ct = {6'h0, 1'(m / 9), 1'((m / 3) % 3 == 2), 1'((m / 3) % 3 != 0), 2'(m % 3), 5'h03};
      wr(ra(2, dmsi_pkg::R_CTRL), ct);
      @(negedge mclk_i);
      chk({15'h0, tx_dreq_o[2]}, 16'h0001);
      @(posedge mclk_i);
      d = 9'($random(seed));
      bp = ct[7] && (($random(seed) & 3) == 0);
      bs = (($random(seed) & 3) == 0);
      f = frame(d, ct, bp, bs, n);
      g = frame(d, ct, 1'b0, 1'b0, n);
      fork
        wr(ra(2, dmsi_pkg::R_DATA), {7'h0, d});
        u_dmsi_peer.recv(f, n, 16);
        u_dmsi_peer.send(f, n, 16);
      join
      chk({3'h0, f}, {3'h0, g});
      repeat (23) @(posedge mclk_i);
      @(negedge mclk_i);
      chk({15'h0, rx_dreq_o[2]}, 16'h0001);
      @(posedge mclk_i);
      rd(ra(2, dmsi_pkg::R_STAT), v);
      chk(v & 16'h00ff, {8'h0, bp | bs, bs, bp, 5'h0d});
      rd(ra(2, dmsi_pkg::R_DATA), v);
      chk(v, 16'(d) & 16'((1 << (7 + int'(ct[6:5]))) - 1));
      wr(ra(2, dmsi_pkg::R_STAT), 16'h0074);
    end
    // Second character lands on an unread one
    u_dmsi_peer.send(frame(9'h0a5, ct, 1'b0, 1'b0, n), n, 16);
    @(posedge mclk_i);
    u_dmsi_peer.send(frame(9'h15a, ct, 1'b0, 1'b0, n), n, 16);
    repeat (24) @(posedge mclk_i);
    rd(ra(2, dmsi_pkg::R_STAT), v);
    chk(v & 16'h00f8, 16'h0098);
    rd(ra(2, dmsi_pkg::R_DATA), v);
    chk(v, 16'h015a);
    // Synchronous loopback, internal clock, half period of eight clocks
    wr(ra(1, dmsi_pkg::R_BAUD), 16'h0007);
    wr(ra(1, dmsi_pkg::R_CTRL), 16'h0007);
    for (int j = 0; j < 3; j++)
    begin
      d = 9'($random(seed) & 8'hff);
      wr(ra(1, dmsi_pkg::R_DATA), {7'h0, d});
      k = 0;
      n = 0;
      s = sclk_o[1];
      repeat (300)
      begin
        @(negedge mclk_i);
        if (sclk_o[1] === 1'b1 && s === 1'b0)
          sh = {txd_o[1], sh[7:1]};
        k += int'(sclk_o[1] !== s);
        n += int'(sclk_o[1] === 1'b0);
        s = sclk_o[1];
      end
      @(posedge mclk_i);
      chk(16'(k), 16'd16);
      chk(16'(n), 16'd64);
      chk({8'h0, sh}, {8'h0, d[7:0]});
      if (j == 0)
      begin
        rd(ra(1, dmsi_pkg::R_STAT), v);
        chk(v & 16'h00f8, 16'h0008);
        rd(ra(1, dmsi_pkg::R_DATA), v);
        chk(v, 16'(d[7:0]));
      end
    end
    rd(ra(1, dmsi_pkg::R_STAT), v);
    chk(v & 16'h0070, 16'h0010);
    // External clock, idle low, peer keeps it at clock/32
    wr(ra(0, dmsi_pkg::R_CTRL), 16'h001f);
    d = 9'($random(seed) & 8'hff);
    wr(ra(0, dmsi_pkg::R_DATA), {7'h0, d});
    for (int i = 0; i < 16; i++)
    begin
      if (i % 2 == 1)
        sh = {txd_o[0], sh[7:1]};
      sclk_w[0] <= ~sclk_w[0];
      repeat (16) @(posedge mclk_i);
    end
    chk({15'h0, sclk_oe_o[0]}, 16'h0000);
    chk({8'h0, sh}, {8'h0, d[7:0]});
    rd(ra(0, dmsi_pkg::R_STAT), v);
    chk(v & 16'h000e, 16'h0008);
    rd(ra(0, dmsi_pkg::R_DATA), v);
    chk(v, 16'(d[7:0]));
    // Each count source: data bit lasts sixteen divider ticks
    wr(ra(3, dmsi_pkg::R_BAUD), 16'h0000);
    for (int s3 = 0; s3 < 4; s3++)
    begin
      wr(ra(3, dmsi_pkg::R_CTRL), 16'h0021 | (16'(s3) << 10));
      wr(ra(3, dmsi_pkg::R_DATA), 16'h0001);
      n = 0;
      while (txd_o[3] !== 1'b0 && n < 9000)
      begin
        @(negedge mclk_i);
        n++;
      end
      while (txd_o[3] !== 1'b1 && n < 18000)
      begin
        @(negedge mclk_i);
        n++;
      end
      k = 0;
      while (txd_o[3] === 1'b1 && k < 9000)
      begin
        @(negedge mclk_i);
        k++;
      end
      @(posedge mclk_i);
      chk(16'(k), 16'(16 * dv[s3]));
      v = 16'h0002;
      for (int p = 0; p < 15000 && v[1] !== 1'b0; p++)
        rd(ra(3, dmsi_pkg::R_STAT), v);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
